// *** mic_device.sv ***
// Device end: interrupt, wake-on-motion, power mode and FIFO bookkeeping logic
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
module mic_device #(
    parameter int FIFO_DEPTH = 1024
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // Host link
    mic_if.device link,
    // Sensor front end
    input wire logic sample_valid,
    input wire logic signed [15:0] accel_hp_x,
    input wire logic signed [15:0] accel_hp_y,
    input wire logic signed [15:0] accel_hp_z,
    input wire logic [15:0] temp_value,
    input wire logic frame_sync_in,
    input wire logic clk_locked,
    // Status to the analog side
    output logic [2:0] power_mode,
    output logic clk_auto_select,
    output logic wake_tick
);
    import mic_pkg::*;

    logic [7:0] sample_rate_divider;
    logic [7:0] accel_filter_config;
    logic [7:0] motion_threshold [3];
    logic [7:0] irq_cfg;
    logic [7:0] irq_source_enable;
    logic [7:0] irq_status;
    logic [7:0] fifo_cfg;
    logic [7:0] motion_logic_control;
    logic [7:0] power_control_primary;
    logic [7:0] power_control_axes;
    logic [15:0] temp_reg;
    logic [15:0] fifo_count;
    logic [7:0] fifo_mem [FIFO_DEPTH];
    logic [9:0] fifo_wptr;
    logic [9:0] fifo_rptr;
    logic [7:0] wake_cnt;
    logic frame_sync_in_d;
    logic lock_d;
    logic [2:0] axis_hit;
    logic motion_evt;
    logic [7:0] events;
    logic [7:0] rd_clear;
    logic fifo_push;
    logic fifo_pop;
    logic sample_take;
    logic level_a;
    logic level_b;

    function automatic logic [15:0] magnitude(input logic signed [15:0] v);
        magnitude = v[15] ? 16'(-v) : 16'(v);
    endfunction

    // Register writes
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            sample_rate_divider <= RST_ZERO;
            accel_filter_config <= RST_ZERO;
            motion_threshold[0] <= RST_ZERO;
            motion_threshold[1] <= RST_ZERO;
            motion_threshold[2] <= RST_ZERO;
            irq_cfg <= RST_ZERO;
            irq_source_enable <= RST_ZERO;
            fifo_cfg <= RST_ZERO;
            motion_logic_control <= RST_ZERO;
            power_control_primary <= RST_PWR1;
            power_control_axes <= RST_ZERO;
        end else if (link.wr) begin
            unique case (link.addr)
                ADDR_SMPL_DIV: sample_rate_divider <= link.wdata;
                ADDR_ACC_FILT: accel_filter_config <= link.wdata;
                ADDR_THR_X: motion_threshold[0] <= link.wdata;
                ADDR_THR_Y: motion_threshold[1] <= link.wdata;
                ADDR_THR_Z: motion_threshold[2] <= link.wdata;
                ADDR_IRQ_CFG: irq_cfg <= link.wdata;
                ADDR_IRQ_EN: irq_source_enable <= link.wdata;
                ADDR_FIFO_CFG: fifo_cfg <= link.wdata;
                ADDR_MOT_CTRL: motion_logic_control <= link.wdata;
                ADDR_PWR1: power_control_primary <= link.wdata;
                ADDR_PWR2: power_control_axes <= link.wdata;
                default: ;
            endcase
        end
    end

    // Power mode from sleep, cycle and standby bits
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            power_mode <= PM_SLEEP;
            clk_auto_select <= 1'b0;
        end else begin
            clk_auto_select <= power_control_primary[CLKSEL_LSB];
            if (power_control_primary[BIT_SLEEP]) begin
                power_mode <= PM_SLEEP;
            end else if (&power_control_axes[5:3] && &power_control_axes[2:0]) begin
                power_mode <= power_control_primary[BIT_GYRO_STBY] ? PM_STANDBY : PM_SLEEP;
            end else if (&power_control_axes[2:0]) begin
                power_mode <= power_control_primary[BIT_CYCLE] ? PM_ACC_LP : PM_ACC_LN;
            end else if (&power_control_axes[5:3]) begin
                power_mode <= power_control_primary[BIT_CYCLE] ? PM_GYR_LP : PM_GYR_LN;
            end else begin
                power_mode <= power_control_primary[BIT_CYCLE] ? PM_6AX_LP : PM_6AX_LN;
            end
        end
    end

    // Wake-up tick every divider+1 samples, in every power mode
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            wake_cnt <= RST_ZERO;
            wake_tick <= 1'b0;
        end else begin
            wake_tick <= 1'b0;
            if (sample_valid) begin
                if (wake_cnt >= sample_rate_divider) begin
                    wake_cnt <= RST_ZERO;
                    wake_tick <= 1'b1;
                end else begin
                    wake_cnt <= wake_cnt + 8'h01;
                end
            end
        end
    end

    // In cycle mode only wake-up samples count, else every sample
    assign sample_take = sample_valid &&
        (!power_control_primary[BIT_CYCLE] || wake_cnt >= sample_rate_divider);

    // Motion compare per axis, enabled axes only
    assign axis_hit[0] = magnitude(accel_hp_x) > {8'h00, motion_threshold[0]};
    assign axis_hit[1] = magnitude(accel_hp_y) > {8'h00, motion_threshold[1]};
    assign axis_hit[2] = magnitude(accel_hp_z) > {8'h00, motion_threshold[2]};

    always_comb begin
        logic [2:0] en;
        en = irq_source_enable[BIT_MOT_Z:BIT_MOT_X];
        if (motion_logic_control[BIT_COMBINE]) begin
            motion_evt = (en != 3'h0) && ((axis_hit & en) == en);
        end else begin
            motion_evt = |(axis_hit & en);
        end
        motion_evt = motion_evt && sample_take && motion_logic_control[BIT_LOGIC_EN];
    end

    // Edge events for frame sync and clock lock
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            frame_sync_in_d <= 1'b0;
            lock_d <= 1'b0;
        end else begin
            frame_sync_in_d <= frame_sync_in;
            lock_d <= clk_locked;
        end
    end

    // FIFO: two temperature bytes per sample when selected, byte pops on data reads
    assign fifo_push = sample_take && fifo_cfg[7];
    assign fifo_pop = link.rd && link.addr == ADDR_FIFO_DATA && fifo_count != 16'h0000;

    always_comb begin
        events = 8'h00;
        events[BIT_DRDY] = sample_take;
        events[BIT_CLK_LOCK] = clk_locked & ~lock_d;
        events[BIT_WMARK] = fifo_push && fifo_count + 16'h0002 >= FIFO_WMARK;
        events[BIT_OVF] = fifo_push && fifo_count + 16'h0002 > FIFO_BYTES;
        events[BIT_FRAME_SYNC_IN] = frame_sync_in & ~frame_sync_in_d;
        events[BIT_MOT_X] = motion_evt && axis_hit[0];
        events[BIT_MOT_Y] = motion_evt && axis_hit[1];
        events[BIT_MOT_Z] = motion_evt && axis_hit[2];
        events = events & irq_source_enable;
    end

    // Status read clears flags, or any read when selected
    assign rd_clear = (link.rd && (link.addr == ADDR_IRQ_STAT || irq_cfg[BIT_CLR_ANY_RD]))
                      ? 8'hff : 8'h00;

    // Set wins over clear; non-latched mode follows events, keeping flags while another register is read
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_status <= RST_ZERO;
        end else if (irq_cfg[BIT_LATCH]) begin
            irq_status <= (irq_status & ~rd_clear) | events;
        end else begin
            irq_status <= events | (irq_status & {8{link.rd && link.addr != ADDR_IRQ_STAT}});
        end
    end

    // FIFO storage and counter; overflow drops the oldest bytes
    always_ff @(posedge core_clk) begin
        if (fifo_push) begin
            fifo_mem[fifo_wptr] <= temp_value[15:8];
            fifo_mem[10'(fifo_wptr + 10'h001)] <= temp_value[7:0];
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            fifo_wptr <= 10'h000;
            fifo_rptr <= 10'h000;
            fifo_count <= 16'h0000;
        end else begin
            if (fifo_push) begin
                fifo_wptr <= fifo_wptr + 10'h002;
            end
            if (fifo_push && fifo_count + 16'h0002 > FIFO_BYTES) begin
                fifo_rptr <= fifo_rptr + 10'h002;
                fifo_count <= FIFO_BYTES;
            end else if (fifo_push) begin
                fifo_count <= fifo_count + 16'h0002 - {15'h0000, fifo_pop};
                fifo_rptr <= fifo_rptr + {9'h000, fifo_pop};
            end else if (fifo_pop) begin
                fifo_count <= fifo_count - 16'h0001;
                fifo_rptr <= fifo_rptr + 10'h001;
            end
        end
    end

    // Latest temperature, never written by the host
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            temp_reg <= 16'h0000;
        end else if (sample_valid) begin
            temp_reg <= temp_value;
        end
    end

    // Read data one cycle after the strobe
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            link.rdata <= RST_ZERO;
        end else if (link.rd) begin
            unique case (link.addr)
                ADDR_SMPL_DIV: link.rdata <= sample_rate_divider;
                ADDR_ACC_FILT: link.rdata <= accel_filter_config;
                ADDR_THR_X: link.rdata <= motion_threshold[0];
                ADDR_THR_Y: link.rdata <= motion_threshold[1];
                ADDR_THR_Z: link.rdata <= motion_threshold[2];
                ADDR_IRQ_CFG: link.rdata <= irq_cfg;
                ADDR_IRQ_EN: link.rdata <= irq_source_enable;
                ADDR_IRQ_STAT: link.rdata <= irq_status;
                ADDR_TEMP: link.rdata <= temp_reg[15:8];
                ADDR_TEMP_LO: link.rdata <= temp_reg[7:0];
                ADDR_FIFO_CFG: link.rdata <= fifo_cfg;
                ADDR_FIFO_CNT: link.rdata <= fifo_count[15:8];
                ADDR_FIFO_CNT_LO: link.rdata <= fifo_count[7:0];
                ADDR_FIFO_DATA: link.rdata <= fifo_mem[fifo_rptr];
                ADDR_MOT_CTRL: link.rdata <= motion_logic_control;
                ADDR_PWR1: link.rdata <= power_control_primary;
                ADDR_PWR2: link.rdata <= power_control_axes;
                default: link.rdata <= RST_ZERO;
            endcase
        end
    end

    // Pin routing and drive style
    assign level_a = |(irq_status & irq_source_enable & 8'h05);
    assign level_b = |(irq_status & irq_source_enable & 8'hf8);

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            link.irq_out_a_o <= 1'b0;
            link.irq_out_a_oe <= 1'b1;
            link.irq_out_b_o <= 1'b0;
            link.irq_out_b_oe <= 1'b1;
        end else begin
            link.irq_out_a_o <= level_a ^ irq_cfg[BIT_ACT_LOW];
            link.irq_out_b_o <= level_b ^ irq_cfg[BIT_ACT_LOW];
            // Open drain drives only the low level
            link.irq_out_a_oe <= !irq_cfg[BIT_OPEN_DRAIN] || !(level_a ^ irq_cfg[BIT_ACT_LOW]);
            link.irq_out_b_oe <= !irq_cfg[BIT_OPEN_DRAIN] || !(level_b ^ irq_cfg[BIT_ACT_LOW]);
        end
    end
endmodule

// *** mic_host.sv ***
// Host end: forwards register commands and reports interrupt pin levels
`timescale 1ns/1ps
module mic_host (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // Device link
    mic_if.host link,
    // User command port
    input wire logic [6:0] cmd_addr,
    input wire logic [7:0] cmd_wdata,
    input wire logic cmd_wr,
    input wire logic cmd_rd,
    output logic [7:0] cmd_rdata,
    output logic cmd_rvalid,
    output logic irq_a_seen,
    output logic irq_b_seen
);
    import mic_pkg::*;
    logic rd_d;

    // Strobes pass straight through, a read only when no write is strobed; the device never stalls
    assign link.addr = cmd_addr;
    assign link.wdata = cmd_wdata;
    assign link.wr = cmd_wr;
    assign link.rd = cmd_rd & ~cmd_wr;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_d <= 1'b0;
        end else begin
            rd_d <= cmd_rd & ~cmd_wr;
        end
    end

    // Read data appear one cycle after the strobe and reach the user register one cycle later, kept there until the next read
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            cmd_rdata <= RST_ZERO;
            cmd_rvalid <= 1'b0;
        end else begin
            cmd_rvalid <= rd_d;
            if (rd_d) begin
                cmd_rdata <= link.rdata;
            end
        end
    end

    // Pin level resolved from enable; undriven open-drain pin counts as pulled high
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_a_seen <= 1'b0;
            irq_b_seen <= 1'b0;
        end else begin
            irq_a_seen <= link.irq_out_a_oe ? link.irq_out_a_o : 1'b1;
            irq_b_seen <= link.irq_out_b_oe ? link.irq_out_b_o : 1'b1;
        end
    end
endmodule

// *** mic_if.sv ***
// Register port and interrupt pins between host and motion interrupt controller
`timescale 1ns/1ps
interface mic_if;
    logic [6:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic [7:0] rdata;
    logic irq_out_a_o;
    logic irq_out_a_oe;
    logic irq_out_b_o;
    logic irq_out_b_oe;
    modport device (input addr, wdata, wr, rd, output rdata,
                    output irq_out_a_o, irq_out_a_oe, irq_out_b_o, irq_out_b_oe);
    modport host (output addr, wdata, wr, rd, input rdata,
                  input irq_out_a_o, irq_out_a_oe, irq_out_b_o, irq_out_b_oe);
endinterface

// *** mic_pkg.sv ***
// Shared register map, field positions and reset values for the motion interrupt controller
package mic_pkg;
    localparam logic [6:0] ADDR_SMPL_DIV = 7'h19;
    localparam logic [6:0] ADDR_ACC_FILT = 7'h1d;
    localparam logic [6:0] ADDR_THR_X = 7'h20;
    localparam logic [6:0] ADDR_THR_Y = 7'h21;
    localparam logic [6:0] ADDR_THR_Z = 7'h22;
    localparam logic [6:0] ADDR_IRQ_CFG = 7'h37;
    localparam logic [6:0] ADDR_IRQ_EN = 7'h38;
    localparam logic [6:0] ADDR_IRQ_STAT = 7'h3a;
    localparam logic [6:0] ADDR_TEMP = 7'h41;
    localparam logic [6:0] ADDR_TEMP_LO = 7'h42;
    localparam logic [6:0] ADDR_FIFO_CNT_LO = 7'h73;
    localparam logic [6:0] ADDR_FIFO_CFG = 7'h23;
    localparam logic [6:0] ADDR_FIFO_CNT = 7'h72;
    localparam logic [6:0] ADDR_FIFO_DATA = 7'h74;
    localparam logic [6:0] ADDR_MOT_CTRL = 7'h69;
    localparam logic [6:0] ADDR_PWR1 = 7'h6b;
    localparam logic [6:0] ADDR_PWR2 = 7'h6c;
    // Interrupt enable and status bit positions
    localparam int BIT_DRDY = 0;
    localparam int BIT_CLK_LOCK = 1;
    localparam int BIT_FRAME_SYNC_IN = 3;
    localparam int BIT_WMARK = 2;
    localparam int BIT_OVF = 4;
    localparam int BIT_MOT_X = 5;
    localparam int BIT_MOT_Y = 6;
    localparam int BIT_MOT_Z = 7;
    // Irq config bits
    localparam int BIT_OPEN_DRAIN = 6;
    localparam int BIT_LATCH = 5;
    localparam int BIT_CLR_ANY_RD = 4;
    localparam int BIT_ACT_LOW = 7;
    // Motion control bits
    localparam int BIT_COMBINE = 0;
    localparam int BIT_CMP_MODE = 6;
    localparam int BIT_LOGIC_EN = 7;
    // Power control bits
    localparam int BIT_CYCLE = 5;
    localparam int BIT_SLEEP = 6;
    localparam int BIT_GYRO_STBY = 4;
    localparam int CLKSEL_LSB = 0;
    localparam logic [7:0] RST_PWR1 = 8'h41;
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [15:0] FIFO_BYTES = 16'h0400;
    localparam logic [15:0] FIFO_WMARK = 16'h0200;
    typedef enum logic [2:0] {
        PM_SLEEP = 3'h0, PM_STANDBY = 3'h1, PM_ACC_LP = 3'h2, PM_ACC_LN = 3'h3,
        PM_GYR_LP = 3'h4, PM_GYR_LN = 3'h5, PM_6AX_LN = 3'h6, PM_6AX_LP = 3'h7
    } mic_pmode_e;
endpackage

// *** mic_props.sv ***
// Interface-level property checker for the motion interrupt controller link
`timescale 1ns/1ps
module mic_props (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // Register port
    input wire logic [6:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] rdata,
    // Interrupt pins
    input wire logic irq_out_a_o,
    input wire logic irq_out_a_oe,
    input wire logic irq_out_b_o,
    input wire logic irq_out_b_oe
);
    import mic_pkg::*;
    logic [7:0] thr_x;
    logic [7:0] irq_en;
    logic [7:0] irq_cfg;
    // Shadows of host writes; the device clears these registers on reset
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            thr_x <= 8'h00;
            irq_en <= 8'h00;
            irq_cfg <= 8'h00;
        end else if (wr) begin
            if (addr == ADDR_THR_X) thr_x <= wdata;
            if (addr == ADDR_IRQ_EN) irq_en <= wdata;
            if (addr == ADDR_IRQ_CFG) irq_cfg <= wdata;
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    thr_readback_a: assert property (
        rd && addr == ADDR_THR_X |=> rdata == thr_x) else $error("threshold readback wrong");
    en_readback_a: assert property (
        rd && addr == ADDR_IRQ_EN |=> rdata == irq_en) else $error("enable readback wrong");
    cfg_readback_a: assert property (
        rd && addr == ADDR_IRQ_CFG |=> rdata == irq_cfg) else $error("config readback wrong");
    // Three cycles of margin cover the registered status and pin stages
    pin_a_quiet_a: assert property (
        (irq_cfg[7:6] == 2'b00 && (irq_en & 8'h05) == 8'h00)[*3] |-> !irq_out_a_o)
        else $error("pin a active with no routed enable");
    pin_b_quiet_a: assert property (
        (irq_cfg[7:6] == 2'b00 && (irq_en & 8'hf8) == 8'h00)[*3] |-> !irq_out_b_o)
        else $error("pin b active with no routed enable");
    push_pull_a: assert property (
        (!irq_cfg[6])[*2] |-> irq_out_a_oe && irq_out_b_oe) else $error("push-pull pin released");
    open_drain_a: assert property (
        (irq_cfg == 8'he0 && irq_en == 8'h00)[*3] |-> !irq_out_a_oe && !irq_out_b_oe)
        else $error("idle open-drain pin driven");
    rise_b_cause_a: assert property (
        $rose(irq_out_b_o) && irq_cfg[7:6] == 2'b00 |-> ((irq_en | $past(irq_en)) & 8'hf8) != 8'h00)
        else $error("pin b rose without a routed enable");
    cover property ($rose(irq_out_a_o));
    cover property ($rose(irq_out_b_o));
    cover property (rd && addr == ADDR_IRQ_STAT ##1 rdata != 8'h00);
endmodule

// *** motion_interrupt_controller_tb.sv ***
// Self-checking bench joining host and device ends of the motion interrupt controller
`timescale 1ns/1ps
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin miscompares++; \
    $display("mismatch at %0t got %h want %h", $time, got, exp); end end
module motion_interrupt_controller_tb;
    import mic_pkg::*;
    localparam logic signed [15:0] BIG = 16'sh7000;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [6:0] cmd_addr = 7'h00;
    logic [7:0] cmd_wdata = 8'h00;
    logic cmd_wr = 1'b0, cmd_rd = 1'b0, sample_valid = 1'b0, frame_sync_in = 1'b0;
    logic clk_locked = 1'b0;
    logic signed [15:0] ax = 16'sh0000, ay = 16'sh0000, az = 16'sh0000;
    logic [15:0] temp_value = 16'h0000;
    logic [7:0] cmd_rdata, d, dh;
    logic cmd_rvalid, irq_a_seen, irq_b_seen, clk_auto_select, wake_tick;
    logic [2:0] power_mode;
    int miscompares = 0, compares = 0, ticks = 0;
    integer seed = 32'he9bce221;
    logic [6:0] rw_addr [6] = '{ADDR_THR_X, ADDR_THR_Y, ADDR_THR_Z, ADDR_SMPL_DIV, ADDR_ACC_FILT,
        ADDR_IRQ_EN};
    // Standby needs every axis off with the gyro drive-only bit set
    logic [7:0] pm_p1 [9] = '{8'h41, 8'h11, 8'h21, 8'h01, 8'h01, 8'h01, 8'h00, 8'h21, 8'h20};
    logic [7:0] pm_p2 [9] = '{8'h00, 8'h3f, 8'h07, 8'h07, 8'h38, 8'h00, 8'h00, 8'h38, 8'h00};
    mic_pmode_e pm_exp [9] = '{PM_SLEEP, PM_STANDBY, PM_ACC_LP, PM_ACC_LN, PM_GYR_LN, PM_6AX_LN,
        PM_6AX_LN, PM_GYR_LP, PM_6AX_LP};
    always #5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        if (wake_tick === 1'b1) ticks++;
    end
    mic_if link();
    mic_host u_mic_host (.core_clk(core_clk), .reset_n(reset_n), .link(link), .cmd_addr(cmd_addr),
        .cmd_wdata(cmd_wdata), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_rdata(cmd_rdata),
        .cmd_rvalid(cmd_rvalid), .irq_a_seen(irq_a_seen), .irq_b_seen(irq_b_seen));
    mic_device #(.FIFO_DEPTH(1024)) u_mic_device (.core_clk(core_clk), .reset_n(reset_n),
        .link(link), .sample_valid(sample_valid), .accel_hp_x(ax), .accel_hp_y(ay),
        .accel_hp_z(az), .temp_value(temp_value), .frame_sync_in(frame_sync_in),
        .clk_locked(clk_locked), .power_mode(power_mode), .clk_auto_select(clk_auto_select),
        .wake_tick(wake_tick));
    mic_props u_props (.core_clk(core_clk), .reset_n(reset_n), .addr(link.addr),
        .wdata(link.wdata), .wr(link.wr), .rd(link.rd), .rdata(link.rdata),
        .irq_out_a_o(link.irq_out_a_o), .irq_out_a_oe(link.irq_out_a_oe),
        .irq_out_b_o(link.irq_out_b_o), .irq_out_b_oe(link.irq_out_b_oe));
    task automatic close_out();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic wr_reg(input logic [6:0] a, input logic [7:0] v);
        @(posedge core_clk);
        cmd_addr <= a;
        cmd_wdata <= v;
        cmd_wr <= 1'b1;
        @(posedge core_clk);
        cmd_wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [6:0] a, output logic [7:0] v);
        int n;
        @(posedge core_clk);
        cmd_addr <= a;
        cmd_rd <= 1'b1;
        @(posedge core_clk);
        cmd_rd <= 1'b0;
        n = 0;
        do begin
            @(negedge core_clk);
            n++;
        end while (cmd_rvalid !== 1'b1 && n < 8);
        if (cmd_rvalid !== 1'b1) begin
            miscompares++;
            close_out();
        end
        v = cmd_rdata;
    endtask
    task automatic fifo_count(output logic [15:0] c);
        logic [7:0] hi;
        logic [7:0] lo;
        rd_reg(ADDR_FIFO_CNT, hi);
        rd_reg(ADDR_FIFO_CNT + 7'h01, lo);
        c = {hi, lo};
    endtask
    task automatic pulse_sample(input logic signed [15:0] x, input logic signed [15:0] y,
        input logic signed [15:0] z);
        @(posedge core_clk);
        ax <= x;
        ay <= y;
        az <= z;
        sample_valid <= 1'b1;
        @(posedge core_clk);
        sample_valid <= 1'b0;
    endtask
    // Lock and frame sync are levels; only their rising edge is an event
    task automatic trig(input int k);
        if (k == 1 || k == 3) begin
            @(posedge core_clk);
            clk_locked <= (k == 1);
            frame_sync_in <= (k == 3);
            @(posedge core_clk);
            clk_locked <= 1'b0;
            frame_sync_in <= 1'b0;
        end else begin
            pulse_sample(k == 5 ? BIG : 16'sh0000, k == 6 ? -BIG : 16'sh0000,
                k == 7 ? BIG : 16'sh0000);
        end
        repeat (4) @(negedge core_clk);
    endtask
    initial begin
        logic [15:0] c;
        repeat (20) @(posedge core_clk);
        reset_n <= 1'b1;
        rd_reg(ADDR_PWR1, d);
        `CHK(d, RST_PWR1)
        foreach (rw_addr[i]) begin
            dh = 8'($random(seed));
            wr_reg(rw_addr[i], dh);
            rd_reg(rw_addr[i], d);
            `CHK(d, dh)
        end
        for (int i = 0; i < 3; i++) wr_reg(rw_addr[i], 8'h10);
        wr_reg(ADDR_IRQ_EN, 8'h00);
        wr_reg(ADDR_PWR1, 8'h01);
        wr_reg(ADDR_PWR2, 8'h07);
        wr_reg(ADDR_ACC_FILT, 8'h09);
        wr_reg(ADDR_MOT_CTRL, 8'hc0);
        wr_reg(ADDR_IRQ_CFG, 8'h20);
        rd_reg(ADDR_IRQ_CFG, d);
        `CHK(d, 8'h20)
        dh = 8'($random(seed));
        @(posedge core_clk);
        temp_value <= {dh, ~dh};
        pulse_sample(16'sh0000, 16'sh0000, 16'sh0000);
        rd_reg(ADDR_TEMP, d);
        `CHK(d, dh)
        rd_reg(ADDR_TEMP + 7'h01, d);
        `CHK(d, ~dh)
        wr_reg(ADDR_TEMP, ~dh);
        rd_reg(ADDR_TEMP, d);
        `CHK(d, dh)
        // One source enabled at a time; watermark and overflow come from the fill below
        for (int k = 0; k < 8; k++) begin
            if (k == 2 || k == 4) continue;
            rd_reg(ADDR_IRQ_STAT, d);
            wr_reg(ADDR_IRQ_EN, 8'h01 << k);
            trig(k);
            `CHK(irq_a_seen, 1'(k == 0))
            `CHK(irq_b_seen, 1'(k >= 3))
            rd_reg(ADDR_IRQ_STAT, d);
            `CHK(d[k], 1'b1)
            repeat (4) @(negedge core_clk);
            `CHK({irq_a_seen, irq_b_seen}, 2'b00)
        end
        wr_reg(ADDR_IRQ_EN, 8'h00);
        wr_reg(ADDR_IRQ_CFG, 8'he0);
        // Let the released pins settle with nothing enabled
        repeat (4) @(negedge core_clk);
        wr_reg(ADDR_IRQ_EN, 8'h01);
        repeat (4) @(negedge core_clk);
        `CHK({link.irq_out_a_oe, irq_a_seen}, 2'b01)
        trig(0);
        `CHK(irq_a_seen, 1'b0)
        wr_reg(ADDR_IRQ_CFG, 8'h20);
        wr_reg(ADDR_IRQ_EN, 8'h20);
        rd_reg(ADDR_IRQ_STAT, d);
        trig(6);
        rd_reg(ADDR_IRQ_STAT, d);
        `CHK(d[7:5], 3'b000)
        wr_reg(ADDR_MOT_CTRL, 8'hc1);
        wr_reg(ADDR_IRQ_EN, 8'he0);
        trig(5);
        rd_reg(ADDR_IRQ_STAT, d);
        `CHK(d[7:5], 3'b000)
        pulse_sample(-BIG, BIG, -BIG);
        rd_reg(ADDR_IRQ_STAT, d);
        `CHK(d[7:5] != 3'b000, 1'b1)
        wr_reg(ADDR_MOT_CTRL, 8'hc0);
        wr_reg(ADDR_IRQ_EN, 8'h04);
        wr_reg(ADDR_FIFO_CFG, 8'h80);
        repeat (260) pulse_sample(16'sh0000, 16'sh0000, 16'sh0000);
        rd_reg(ADDR_IRQ_STAT, d);
        `CHK(d[BIT_WMARK], 1'b1)
        wr_reg(ADDR_IRQ_EN, 8'h10);
        repeat (260) pulse_sample(16'sh0000, 16'sh0000, 16'sh0000);
        repeat (4) @(negedge core_clk);
        `CHK(irq_b_seen, 1'b1)
        wr_reg(ADDR_FIFO_CFG, 8'h00);
        fifo_count(c);
        `CHK(c, FIFO_BYTES)
        // Oldest entries were dropped in pairs, so reads start on a high byte
        for (int i = 0; i < 4; i++) begin
            rd_reg(ADDR_FIFO_DATA, d);
            `CHK(d, (i % 2 == 1) ? ~dh : dh)
        end
        fifo_count(c);
        `CHK(c, FIFO_BYTES - 16'h0004)
        // Clear on any read, then non-latched flags that last one cycle
        wr_reg(ADDR_IRQ_CFG, 8'h30);
        wr_reg(ADDR_IRQ_EN, 8'h01);
        pulse_sample(16'sh0000, 16'sh0000, 16'sh0000);
        rd_reg(ADDR_PWR1, d);
        rd_reg(ADDR_IRQ_STAT, d);
        `CHK(d[BIT_DRDY], 1'b0)
        wr_reg(ADDR_IRQ_CFG, 8'h00);
        pulse_sample(16'sh0000, 16'sh0000, 16'sh0000);
        rd_reg(ADDR_IRQ_STAT, d);
        `CHK(d[BIT_DRDY], 1'b0)
        for (int i = 0; i < 9; i++) begin
            wr_reg(ADDR_PWR1, pm_p1[i]);
            wr_reg(ADDR_PWR2, pm_p2[i]);
            repeat (3) @(negedge core_clk);
            `CHK(power_mode, pm_exp[i])
            `CHK(clk_auto_select, pm_p1[i][0])
        end
        wr_reg(ADDR_SMPL_DIV, 8'h02);
        wr_reg(ADDR_PWR2, 8'h07);
        wr_reg(ADDR_PWR1, 8'h21);
        ticks = 0;
        repeat (9) pulse_sample(16'sh0000, 16'sh0000, 16'sh0000);
        repeat (4) @(negedge core_clk);
        `CHK(ticks, 3)
        rd_reg(ADDR_FIFO_DATA, d);
        fifo_count(c);
        `CHK(c, FIFO_BYTES - 16'h0005)
        close_out();
    end
endmodule
